/* File: include/ppct_defines.svh */
// register offsets, field positions, masks and reset values
`ifndef PPCT_DEFINES_SVH
`define PPCT_DEFINES_SVH

`define PPCT_OFS_CTRL 5'h00
`define PPCT_OFS_MODE 5'h04
`define PPCT_OFS_ADDR 5'h08
`define PPCT_OFS_DOUT 5'h0C
`define PPCT_OFS_RDGO 5'h10

`define PPCT_CTRL_ON 15
`define PPCT_CTRL_STOP_IN_IDLE 13
`define PPCT_CTRL_MUX 11
`define PPCT_CTRL_WREN 9
`define PPCT_CTRL_RDEN 8
`define PPCT_CTRL_CSF 6
`define PPCT_CTRL_ALP 5
`define PPCT_CTRL_CSP 3
`define PPCT_CTRL_WRITE_STROBE_POLARITY 1
`define PPCT_CTRL_READ_STROBE_POLARITY 0

`define PPCT_MODE_BUSY 15
`define PPCT_MODE_INTERRUPT_MODE 13
`define PPCT_MODE_INCREMENT_MODE 11
`define PPCT_MODE_PMOD 8
`define PPCT_MODE_SETUP_WAIT_STATES 6
`define PPCT_MODE_STROBE_WAIT_STATES 2
`define PPCT_MODE_HOLD_WAIT_STATES 0

`define PPCT_ADDR_CS 14

`define PPCT_CTRL_MASK 16'hBFEB
`define PPCT_MODE_MASK 16'h7BFF
`define PPCT_ADDR_MASK 16'h47FF
`define PPCT_REG_RESET 16'h0000

`endif

/* File: include/ppct_pkg.sv */
// types of the parallel port control and timing block
package ppct_pkg;

   typedef enum logic [2:0] {
      PPCT_IDLE,
      PPCT_ALO,
      PPCT_AHI,
      PPCT_SETUP,
      PPCT_STROBE,
      PPCT_HOLD
   } ppct_fsm_e;

   typedef struct packed {
      logic [15:0] lines;
      logic [7:0] data;
      logic data_oe;
      logic rd;
      logic rd_oe;
      logic wr;
      logic wr_oe;
      logic evt;
   } ppct_pins_s;

   typedef struct packed {
      ppct_fsm_e fsm;
      logic [3:0] cnt;
      logic is_rd;
      logic [15:0] ctrl;
      logic [15:0] mode;
      logic [15:0] addr;
      logic [7:0] dout;
      logic [7:0] din;
      logic [7:0] s1;
      logic [7:0] s2;
      logic waitrq;
      logic [31:0] rdata;
      ppct_pins_s pins;
   } ppct_state_s;

endpackage : ppct_pkg

/* File: logic/ppct_top.sv */
// parallel port control, mode, address and master access timing
module ppct_top
   import ppct_pkg::*;
#(
   parameter int ADDR_W = 5
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic idle_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [15:0] port_address_lines_o,
   input wire logic [7:0] port_data_lines_i,
   output logic [7:0] port_data_lines_o,
   output logic port_data_lines_oe_o,
   output logic read_strobe_o,
   output logic read_strobe_oe_o,
   output logic write_strobe_o,
   output logic write_strobe_oe_o,
   output logic cycle_event_o
);
`include "ppct_defines.svh"

   generate
      if (ADDR_W < 5) begin : g_bad_width
         $error("ppct_top: ADDR_W must be at least 5");
      end
   endgenerate

   ppct_state_s q;
   ppct_state_s n;

   logic on;
   logic stop_in_idle;
   logic [1:0] mux;
   logic [1:0] chip_select_function;
   logic addr_latch_polarity;
   logic csp;
   logic write_strobe_polarity;
   logic read_strobe_polarity;
   logic [1:0] interrupt_mode;
   logic [1:0] increment_mode;
   logic [1:0] pmode;
   logic [1:0] wait_b;
   logic [3:0] wait_m;
   logic [1:0] wait_e;
   logic master;
   logic halt_idle;
   logic busy;
   logic [4:0] ofs;
   logic req;
   logic go_hit;
   logic stall;
   logic grant;
   logic take;
   logic ws0;
   logic [3:0] setup_cnt;
   logic [3:0] whold_cnt;
   logic [1:0] rhold;
   logic [11:0] step_all;
   logic [11:0] step_lo;
   logic cs_mode;

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] be,
      input logic [15:0] mask
   );
      merge16 = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0] : old[7:0]} & mask;
   endfunction

   function automatic logic [11:0] step(
      input logic [11:0] v,
      input logic dn
   );
      step = dn ? v - 12'h001 : v + 12'h001;
   endfunction

   assign on = q.ctrl[`PPCT_CTRL_ON];
   assign stop_in_idle = q.ctrl[`PPCT_CTRL_STOP_IN_IDLE];
   assign mux = q.ctrl[`PPCT_CTRL_MUX +: 2];
   assign chip_select_function = q.ctrl[`PPCT_CTRL_CSF +: 2];
   assign addr_latch_polarity = q.ctrl[`PPCT_CTRL_ALP];
   assign csp = q.ctrl[`PPCT_CTRL_CSP];
   assign write_strobe_polarity = q.ctrl[`PPCT_CTRL_WRITE_STROBE_POLARITY];
   assign read_strobe_polarity = q.ctrl[`PPCT_CTRL_READ_STROBE_POLARITY];
   assign interrupt_mode = q.mode[`PPCT_MODE_INTERRUPT_MODE +: 2];
   assign increment_mode = q.mode[`PPCT_MODE_INCREMENT_MODE +: 2];
   assign pmode = q.mode[`PPCT_MODE_PMOD +: 2];
   assign wait_b = q.mode[`PPCT_MODE_SETUP_WAIT_STATES +: 2];
   assign wait_m = q.mode[`PPCT_MODE_STROBE_WAIT_STATES +: 4];
   assign wait_e = q.mode[`PPCT_MODE_HOLD_WAIT_STATES +: 2];
   assign master = pmode[1];
   assign cs_mode = (chip_select_function == 2'b10);
   assign halt_idle = stop_in_idle & idle_i;
   assign busy = (q.fsm != PPCT_IDLE);

   assign ofs = avs_address_i[4:0];
   assign req = avs_read_i | avs_write_i;
   assign go_hit = avs_write_i &
      ((ofs == `PPCT_OFS_DOUT) | (ofs == `PPCT_OFS_RDGO));
   // a new access waits for the running one instead of being lost
   assign stall = go_hit & on & master & busy;
   assign grant = req & q.waitrq & ~stall;
   assign take = req & ~q.waitrq;

   assign ws0 = (wait_m == 4'h0);
   assign setup_cnt = ws0 ? 4'h0 : {2'b00, wait_b};
   assign whold_cnt = ws0 ? 4'h0 : {2'b00, wait_e};
   assign rhold = ws0 ? 2'b00 : wait_e;

   assign step_all = step({q.addr[14], q.addr[10:0]}, increment_mode[1]);
   assign step_lo = step({1'b0, q.addr[10:0]}, increment_mode[1]);

   always_comb begin
      n = q;
      n.waitrq = 1'b1;
      n.s1 = port_data_lines_i;
      n.s2 = q.s1;
      n.pins.evt = 1'b0;

      if (grant) begin
         n.waitrq = 1'b0;
         case (ofs)
            `PPCT_OFS_CTRL: n.rdata = {16'h0000, q.ctrl};
            `PPCT_OFS_MODE: n.rdata = {16'h0000, busy, q.mode[14:0]};
            `PPCT_OFS_ADDR: n.rdata = {16'h0000, q.addr};
            `PPCT_OFS_DOUT: n.rdata = {24'h00_0000, q.dout};
            `PPCT_OFS_RDGO: n.rdata = {24'h00_0000, q.din};
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // access sequencing
      if (!on) begin
         n.fsm = PPCT_IDLE;
         n.cnt = 4'h0;
      end else if (busy && !halt_idle) begin
         if (q.cnt != 4'h0) begin
            n.cnt = q.cnt - 4'h1;
         end else begin
            case (q.fsm)
               PPCT_ALO: begin
                  n.fsm = (mux == 2'b10) ? PPCT_AHI : PPCT_SETUP;
                  n.cnt = setup_cnt;
               end
               PPCT_AHI: begin
                  n.fsm = PPCT_SETUP;
                  n.cnt = setup_cnt;
               end
               PPCT_SETUP: begin
                  n.fsm = PPCT_STROBE;
                  n.cnt = wait_m;
               end
               PPCT_STROBE: begin
                  if (q.is_rd) begin
                     n.din = q.s2;
                     n.fsm = (rhold == 2'b00) ? PPCT_IDLE : PPCT_HOLD;
                     n.cnt = {2'b00, rhold - 2'b01};
                  end else begin
                     n.fsm = PPCT_HOLD;
                     n.cnt = whold_cnt;
                  end
               end
               PPCT_HOLD: n.fsm = PPCT_IDLE;
               default: n.fsm = PPCT_IDLE;
            endcase
            if (n.fsm == PPCT_IDLE) begin
               n.pins.evt = (interrupt_mode == 2'b01);
               if (increment_mode == 2'b01 || increment_mode == 2'b10) begin
                  if (cs_mode) begin
                     n.addr[10:0] = step_lo[10:0];
                  end else begin
                     n.addr[14] = step_all[11];
                     n.addr[10:0] = step_all[10:0];
                  end
               end
            end
         end
      end

      // register writes land after the hardware address step
      if (take && avs_write_i) begin
         case (ofs)
            `PPCT_OFS_CTRL: n.ctrl = merge16(q.ctrl, avs_writedata_i,
               avs_byteenable_i, `PPCT_CTRL_MASK);
            `PPCT_OFS_MODE: n.mode = merge16(q.mode, avs_writedata_i,
               avs_byteenable_i, `PPCT_MODE_MASK);
            `PPCT_OFS_ADDR: n.addr = merge16(n.addr, avs_writedata_i,
               avs_byteenable_i, `PPCT_ADDR_MASK);
            `PPCT_OFS_DOUT: begin
               if (avs_byteenable_i[0]) begin
                  n.dout = avs_writedata_i[7:0];
               end
            end
            default: ;
         endcase
         if (go_hit && on && master) begin
            n.is_rd = (ofs == `PPCT_OFS_RDGO);
            n.fsm = (mux == 2'b00) ? PPCT_SETUP : PPCT_ALO;
            n.cnt = setup_cnt;
         end
      end

      // pin levels follow the next state so they leave a flip-flop
      n.pins.lines = 16'h0000;
      case (mux)
         2'b00: n.pins.lines[10:0] = n.addr[10:0];
         2'b01: n.pins.lines[10:8] = n.addr[10:8];
         default: ;
      endcase
      if (mux != 2'b00) begin
         n.pins.lines[0] = (n.fsm == PPCT_ALO) ? addr_latch_polarity : ~addr_latch_polarity;
         n.pins.lines[1] = (n.fsm == PPCT_AHI) ? addr_latch_polarity : ~addr_latch_polarity;
      end
      if (cs_mode) begin
         n.pins.lines[14] = n.addr[`PPCT_ADDR_CS] ? csp : ~csp;
      end else if (!mux[1]) begin
         n.pins.lines[14] = n.addr[14];
      end

      n.pins.data = 8'h00;
      n.pins.data_oe = 1'b0;
      case (n.fsm)
         PPCT_ALO: begin
            n.pins.data = n.addr[7:0];
            n.pins.data_oe = on;
         end
         PPCT_AHI: begin
            n.pins.data = {1'b0, n.addr[14] & ~cs_mode, 3'b000,
               n.addr[10:8]};
            n.pins.data_oe = on;
         end
         PPCT_SETUP, PPCT_STROBE, PPCT_HOLD: begin
            n.pins.data = n.is_rd ? 8'h00 : n.dout;
            n.pins.data_oe = on & ~n.is_rd;
         end
         default: ;
      endcase

      if (pmode == 2'b11) begin
         n.pins.rd = (n.fsm != PPCT_IDLE && n.is_rd) ? read_strobe_polarity : ~read_strobe_polarity;
         n.pins.wr = (n.fsm == PPCT_STROBE) ? write_strobe_polarity : ~write_strobe_polarity;
      end else begin
         n.pins.rd = (n.fsm == PPCT_STROBE && n.is_rd) ? read_strobe_polarity : ~read_strobe_polarity;
         n.pins.wr = (n.fsm == PPCT_STROBE && !n.is_rd) ? write_strobe_polarity : ~write_strobe_polarity;
      end
      n.pins.rd_oe = on & master & n.ctrl[`PPCT_CTRL_RDEN];
      n.pins.wr_oe = on & master & n.ctrl[`PPCT_CTRL_WREN];
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         q <= '{fsm: PPCT_IDLE, cnt: 4'h0, is_rd: 1'b0,
                ctrl: `PPCT_REG_RESET, mode: `PPCT_REG_RESET,
                addr: `PPCT_REG_RESET, dout: 8'h00, din: 8'h00,
                s1: 8'h00, s2: 8'h00, waitrq: 1'b1,
                rdata: 32'h0000_0000, pins: '0};
      end else begin
         q <= n;
      end
   end

   assign avs_readdata_o = q.rdata;
   assign avs_waitrequest_o = q.waitrq;
   assign port_address_lines_o = q.pins.lines;
   assign port_data_lines_o = q.pins.data;
   assign port_data_lines_oe_o = q.pins.data_oe;
   assign read_strobe_o = q.pins.rd;
   assign read_strobe_oe_o = q.pins.rd_oe;
   assign write_strobe_o = q.pins.wr;
   assign write_strobe_oe_o = q.pins.wr_oe;
   assign cycle_event_o = q.pins.evt;

endmodule // ppct_top

/* File: tb/ppct_dev.sv */
// external byte-wide device on the far side of the port
module ppct_dev (
   input wire logic mclk_i,
   input wire logic sel_i,
   input wire logic [7:0] rd_byte_i,
   input wire logic [7:0] d_i,
   input wire logic d_oe_i,
   output logic [7:0] d_o,
   output logic [7:0] wr_byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial d_o = 8'h5A;
   // drives read data when selected
   // unselected lines wander so stale data never looks valid
   always @(posedge mclk_i) d_o <= sel_i ? rd_byte_i : ~d_o;
   always @(posedge mclk_i) begin
      if (d_oe_i) wr_byte_o <= d_i;
   end
endmodule // ppct_dev

/* File: tb/ppct_sva.sv */
// pin and bus assertions for the parallel port block
module ppct_sva #(
   parameter int ADDR_W = 5
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [15:0] port_address_lines_o,
   input wire logic port_data_lines_oe_o,
   input wire logic read_strobe_o,
   input wire logic read_strobe_oe_o,
   input wire logic write_strobe_o,
   input wire logic write_strobe_oe_o,
   input wire logic cycle_event_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic [15:0] ctl, md, bm;
   logic go;
   assign bm = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign go = avs_write_i && !avs_waitrequest_o;
   // shadow of control and mode, pin relations depend on them
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctl <= 16'h0000;
         md <= 16'h0000;
      end else if (go && avs_address_i == ADDR_W'(0)) begin
         ctl <= (ctl & ~bm) | (avs_writedata_i[15:0] & bm);
      end else if (go && avs_address_i == ADDR_W'(4)) begin
         md <= (md & ~bm) | (avs_writedata_i[15:0] & bm);
      end
   end
   a_off_no_drive: assert property (
      !ctl[15] ##1 !ctl[15] |-> !port_data_lines_oe_o && !write_strobe_oe_o)
      else $error("pins driven while off");
   a_wr_pin_off: assert property (
      !ctl[9] ##1 !ctl[9] |-> !write_strobe_oe_o)
      else $error("write pin driven");
   a_rd_pin_off: assert property (
      !ctl[8] ##1 !ctl[8] |-> !read_strobe_oe_o)
      else $error("read pin driven");
   a_event_pulse: assert property (
      cycle_event_o |=> !cycle_event_o)
      else $error("event too long");
   a_event_levels: assert property (
      cycle_event_o |-> read_strobe_o == !ctl[0] && write_strobe_o == !ctl[1])
      else $error("strobe active at end");
   a_unused_lines: assert property (
      !port_address_lines_o[15] && port_address_lines_o[13:11] == 3'h0)
      else $error("unused address line set");
   a_upper_zero: assert property (
      avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_strobe_excl: assert property (
      md[9:8] == 2'h2 && $stable(ctl) && $stable(md) && read_strobe_oe_o
      && read_strobe_o == ctl[0] |-> write_strobe_o != ctl[1])
      else $error("both strobes active");
   a_write_data: assert property (
      md[9:8] == 2'h2 && $stable(ctl) && write_strobe_oe_o
      && write_strobe_o == ctl[1] |-> port_data_lines_oe_o)
      else $error("write strobe without data");
endmodule // ppct_sva

bind ppct_top ppct_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

/* File: tb/tb_top.sv */
// self-checking bench for the parallel port control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic idle = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdata, v;
   logic wait_o, doe, rs, rsoe, ws, wsoe, evt;
   logic [15:0] pa;
   logic [7:0] dout, din, dv, wb;
   logic [7:0] rb = 8'h00;
   logic [1:0] b, e;
   logic [3:0] m;
   logic [4:0] ra[4] = '{5'h00, 5'h04, 5'h08, 5'h14};
   logic [15:0] mk[4] = '{16'hBFEB, 16'h7BFF, 16'h47FF, 16'h0000};
   logic [7:0] cb[4] = '{8'hC3, 8'hFF, 8'h48, 8'h00};
   int error_cnt = 0;
   int samples_checked = 0;
   int n;
   logic [31:0] expq[$];

   always #2 clk = ~clk;
   assign din = doe ? dout : dv;

   ppct_top u_dut (.mclk_i(clk), .sys_rst_i(rst), .idle_i(idle),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .port_address_lines_o(pa), .port_data_lines_i(din),
      .port_data_lines_o(dout), .port_data_lines_oe_o(doe),
      .read_strobe_o(rs), .read_strobe_oe_o(rsoe), .write_strobe_o(ws),
      .write_strobe_oe_o(wsoe), .cycle_event_o(evt));
   ppct_dev u_dev (.mclk_i(clk), .sel_i(pa[14]), .rd_byte_i(rb),
      .d_i(dout), .d_oe_i(doe), .d_o(dv), .wr_byte_o(wb));

   task automatic chk(string s, logic [31:0] x, logic [31:0] y);
      samples_checked++;
      if (x !== y) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", s, x, y);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // request held until waitrequest is seen low
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
      int k;
      k = 0;
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         k++;
      end while (wait_o !== 1'b0 && k < 300);
      if (k >= 300) error_cnt++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wrx(logic [4:0] a, logic [31:0] d);
      bus(1'b1, a, d);
      @(posedge clk);
   endtask

   task automatic rdx(logic [4:0] a, logic [31:0] x);
      expq.push_back(x);
      bus(1'b0, a, 32'h0000_0000);
      @(posedge clk);
   endtask

   // start one access, time its phases from the take edge
   task automatic acc(logic w, logic usr, logic lv, int pb, int pm, int ph,
      int frz);
      int t, fs, sc;
      t = 0;
      fs = 0;
      sc = 0;
      idle <= (frz > 0);
      bus(1'b1, w ? 5'h0C : 5'h10, {24'h0, rb});
      while (evt !== 1'b1 && t < 200) begin
         @(posedge clk);
         t++;
         if (t == frz) idle <= 1'b0;
         if ((usr ? rs : ws) === lv) sc++;
         if ((usr ? rs : ws) === lv && fs == 0) fs = t;
      end
      chk("strobe", pm, sc);
      if (frz > 0) chk("frozen", 1, fs > frz);
      else chk("setup", pb + 1, fs);
      if (frz == 0) chk("end", pb + pm + ph + 1, t);
   endtask

   always @(posedge clk) begin
      if (rd && wait_o === 1'b0) chk("rdata", expq.pop_front(), rdata);
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      v = $urandom(84);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ra[i]) rdx(ra[i], 0);
      repeat (4) foreach (ra[i]) begin
         v = $urandom;
         wrx(ra[i], v);
         rdx(ra[i], {16'h0000, v[15:0] & mk[i]});
      end
      for (int k = 0; k < 4; k++) begin
         for (int w = 0; w < 2; w++) begin
            wrx(5'h00, k == 3 ? 32'h838B : 32'h8388);
            wrx(5'h04, {k == 3 ? 8'h23 : (w ? 8'h2A : 8'h32), cb[k]});
            wrx(5'h08, 32'h0000_47FF);
            rb = 8'($urandom);
            {b, m, e} = cb[k];
            acc(w, !w && k != 3, k == 3, m ? b + 1 : 1, m + 1,
               m ? e + w : w, 0);
            chk("cs pin", 1, pa[14]);
            if (w) chk("wbyte", rb, wb);
            else rdx(5'h10, rb);
            rdx(5'h08, k == 3 ? 32'h47FF : (w ? 32'h4000 : 32'h47FE));
         end
      end
      wrx(5'h04, 32'h0000_2AFC);
      bus(1'b1, 5'h0C, 32'h0000_0011);
      @(posedge clk);
      rdx(5'h04, 32'h0000_AAFC);
      n = 0;
      while (evt !== 1'b1 && n < 99) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      rdx(5'h04, 32'h0000_2AFC);
      wrx(5'h00, 32'h0000_A388);
      wrx(5'h04, 32'h0000_2A00);
      acc(1'b1, 1'b0, 1'b0, 1, 1, 1, 12);
      wrx(5'h00, 32'h0000_0388);
      @(posedge clk);
      wrx(5'h0C, 32'h0000_0055);
      repeat (30) begin
         @(posedge clk);
         chk("off pins", 0, {doe, wsoe, rsoe});
      end
      tally_and_finish();
   end
endmodule // tb_top
